/* File: scan_tap.v */
// Boundary scan test access port with bypass, identification and boundary registers.
// Assumes tck is far slower than clk (>= 4 clk cycles per phase) so edges are found by sampling.
//
// What this block does
// RL1: Five test pins drive dedicated scan logic
// RL2: Bypass puts one bit between tdi, tdo
// RL3: Extest drives and observes pins from boundary register
// RL4: Sample captures pins, preloads outputs without disturbing
// RL5: Clamp selects bypass, boundary keeps driving pins
// RL6: Idcode puts identification register on chain
// RL7: Reset state forces idcode, functional pins pass
// RL8: Low trst forces reset state asynchronously
// RL9: Identification is 32 bits: maker, part, version
// RL10: Identification code loaded in capture state
// RL11: Bit 0 shifts out on tdo first
// RL12: Sixteen states on rising tck, tdo falling
`timescale 1ns/1ns
`include "tap_defs.vh"
module scan_tap (
  input wire clk, // System clock
  input wire rstn, // Asynchronous reset, active low
  input wire tck, // Test clock pin
  input wire tms, // Test mode select pin
  input wire tdi, // Test data input pin
  input wire trst_n, // Test reset pin, active low
  output reg tdo, // Test data output
  output reg tdo_oe, // High while tdo is driven
  input wire [`BSR_W-1:0] core_out, // Functional values towards pins
  input wire [`BSR_W-1:0] pin_in, // Values seen at device pins
  output reg [`BSR_W-1:0] pin_out, // Values driven onto pins
  output reg [`BSR_W-1:0] core_in, // Pin values given to the core
  output reg test_mode // High while boundary owns the pins
);
  // ****************************************
  // State codes, one-hot
  // ****************************************
  localparam S_TLR = 16'h0001;
  localparam S_RTI = 16'h0002;
  localparam S_SDR = 16'h0004;
  localparam S_CDR = 16'h0008;
  localparam S_SHDR = 16'h0010;
  localparam S_E1DR = 16'h0020;
  localparam S_PDR = 16'h0040;
  localparam S_E2DR = 16'h0080;
  localparam S_UDR = 16'h0100;
  localparam S_SIR = 16'h0200;
  localparam S_CIR = 16'h0400;
  localparam S_SHIR = 16'h0800;
  localparam S_E1IR = 16'h1000;
  localparam S_PIR = 16'h2000;
  localparam S_E2IR = 16'h4000;
  localparam S_UIR = 16'h8000;

  localparam [`ID_W-1:0] ID_CODE = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1}; // RL9

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Three stages; a change is accepted once stages two and three agree
  reg [2:0] tck_s_r, tms_s_r, tdi_s_r, trst_s_r;
  reg tck_q_r, tms_q_r, tdi_q_r;
  wire [3:0] sync_in = {trst_n, tdi, tms, tck};
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tck_s_r <= 3'h0;
      tms_s_r <= 3'h7;
      tdi_s_r <= 3'h7;
      trst_s_r <= 3'h0;
      tck_q_r <= 1'b0;
      tms_q_r <= 1'b1;
      tdi_q_r <= 1'b1;
    end else begin
      tck_s_r <= {tck_s_r[1:0], sync_in[0]};
      tms_s_r <= {tms_s_r[1:0], sync_in[1]};
      tdi_s_r <= {tdi_s_r[1:0], sync_in[2]};
      trst_s_r <= {trst_s_r[1:0], sync_in[3]};
      if (tck_s_r[1] == tck_s_r[2])
        tck_q_r <= tck_s_r[2];
      if (tms_s_r[1] == tms_s_r[2])
        tms_q_r <= tms_s_r[2];
      if (tdi_s_r[1] == tdi_s_r[2])
        tdi_q_r <= tdi_s_r[2];
    end
  end

  wire tck_rise = (tck_s_r[1] == tck_s_r[2]) && tck_s_r[2] && !tck_q_r; // RL12
  wire tck_fall = (tck_s_r[1] == tck_s_r[2]) && !tck_s_r[2] && tck_q_r; // RL12
  // Test reset acts without any tck edge; its release waits until stages two and three agree,
  // so that no scan flop leaves reset on an arbitrary phase of clk
  wire tap_rst_n = rstn & trst_n & trst_s_r[1] & trst_s_r[2]; // RL8

  // ****************************************
  // Controller
  // ****************************************
  reg [15:0] st_r, st_nxt;
  always @* begin
    case (st_r)
      S_TLR: st_nxt = tms_q_r ? S_TLR : S_RTI;
      S_RTI: st_nxt = tms_q_r ? S_SDR : S_RTI;
      S_SDR: st_nxt = tms_q_r ? S_SIR : S_CDR;
      S_CDR: st_nxt = tms_q_r ? S_E1DR : S_SHDR;
      S_SHDR: st_nxt = tms_q_r ? S_E1DR : S_SHDR;
      S_E1DR: st_nxt = tms_q_r ? S_UDR : S_PDR;
      S_PDR: st_nxt = tms_q_r ? S_E2DR : S_PDR;
      S_E2DR: st_nxt = tms_q_r ? S_UDR : S_SHDR;
      S_UDR: st_nxt = tms_q_r ? S_SDR : S_RTI;
      S_SIR: st_nxt = tms_q_r ? S_TLR : S_CIR;
      S_CIR: st_nxt = tms_q_r ? S_E1IR : S_SHIR;
      S_SHIR: st_nxt = tms_q_r ? S_E1IR : S_SHIR;
      S_E1IR: st_nxt = tms_q_r ? S_UIR : S_PIR;
      S_PIR: st_nxt = tms_q_r ? S_E2IR : S_PIR;
      S_E2IR: st_nxt = tms_q_r ? S_UIR : S_SHIR;
      S_UIR: st_nxt = tms_q_r ? S_SDR : S_RTI;
      default: st_nxt = S_TLR;
    endcase
  end

  // ****************************************
  // Registers on the scan chain
  // ****************************************
  reg [`IR_W-1:0] ir_sh_r, ir_r;
  reg [`ID_W-1:0] id_sh_r;
  reg [`BSR_W-1:0] bsr_sh_r, bsr_up_r;
  reg byp_r;
  // One decoder for every opcode test, so chain select and pin owner cannot disagree
  // Bits: identification chain, boundary chain, pins owned by the update cells
  function [2:0] op_decode;
    input [`IR_W-1:0] op;
    begin
      case (op)
        `IR_EXTEST: op_decode = 3'h3;
        `IR_SAMPLE: op_decode = 3'h2;
        `IR_IDCODE: op_decode = 3'h4;
        `IR_CLAMP: op_decode = 3'h1;
        default: op_decode = 3'h0;
      endcase
    end
  endfunction
  wire [2:0] op_sel = op_decode(ir_r);
  wire sel_bsr = op_sel[1]; // RL3 RL4
  wire sel_id = op_sel[2]; // RL6
  wire drives_pins = op_sel[0]; // RL3 RL5

  always @(posedge clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      st_r <= S_TLR; // RL8
      ir_sh_r <= `IR_CAPT;
      ir_r <= `IR_IDCODE; // RL7
      id_sh_r <= 32'h00000000;
      bsr_sh_r <= 8'h00;
      bsr_up_r <= 8'h00;
      byp_r <= 1'b0;
    end else if (tck_rise) begin
      st_r <= st_nxt; // RL12
      // Forced on entry, so a tester that stops tck in reset still finds the pins released
      if (st_nxt == S_TLR)
        ir_r <= `IR_IDCODE; // RL7
      if (st_r == S_CIR)
        ir_sh_r <= `IR_CAPT;
      if (st_r == S_SHIR)
        ir_sh_r <= {tdi_q_r, ir_sh_r[`IR_W-1:1]};
      if (st_r == S_UIR)
        ir_r <= ir_sh_r;
      if (st_r == S_CDR) begin
        byp_r <= 1'b0; // RL2
        if (sel_id)
          id_sh_r <= ID_CODE; // RL10
        if (sel_bsr)
          bsr_sh_r <= pin_in; // RL3 RL4
      end
      if (st_r == S_SHDR) begin
        byp_r <= tdi_q_r; // RL2 RL5
        if (sel_id)
          id_sh_r <= {tdi_q_r, id_sh_r[`ID_W-1:1]}; // RL11
        if (sel_bsr)
          bsr_sh_r <= {tdi_q_r, bsr_sh_r[`BSR_W-1:1]};
      end
      // Preload lands in the latched cells; they reach pins only under extest or clamp
      if (st_r == S_UDR && sel_bsr)
        bsr_up_r <= bsr_sh_r; // RL4
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  reg tdo_nxt;
  always @* begin
    if (st_r == S_SHIR)
      tdo_nxt = ir_sh_r[0];
    else if (sel_id)
      tdo_nxt = id_sh_r[0]; // RL6 RL11
    else if (sel_bsr)
      tdo_nxt = bsr_sh_r[0];
    else
      tdo_nxt = byp_r; // RL2 RL5
  end

  always @(posedge clk or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      if (tck_fall) begin
        tdo <= tdo_nxt; // RL12
        tdo_oe <= (st_r == S_SHDR) || (st_r == S_SHIR); // RL12
      end
      test_mode <= drives_pins; // RL1
    end
  end

  // ****************************************
  // Functional path
  // ****************************************
  // Only the system reset clears it: a test reset must not blank the pins of a running device
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out <= 8'h00;
      core_in <= 8'h00;
    end else begin
      // Functional path is untouched unless the boundary owns the pins
      pin_out <= drives_pins ? bsr_up_r : core_out; // RL3 RL4 RL5 RL7
      core_in <= pin_in; // RL4
    end
  end
endmodule

/* File: tap_defs.vh */
// Constants for the boundary scan test access port.
// Assumes a single 125 MHz system clock; all test pins are sampled by it.
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
// ****************************************
// Instruction register
// ****************************************
`define IR_W 3
`define IR_EXTEST 3'h0
`define IR_SAMPLE 3'h1
`define IR_IDCODE 3'h2
`define IR_CLAMP 3'h3
`define IR_BYPASS 3'h7
`define IR_CAPT 3'h1
// ****************************************
// Data registers
// ****************************************
`define ID_W 32
`define BSR_W 8
// Identification value is arbitrary: version, part, maker, fixed lsb of one
`define ID_VERSION 4'h1
`define ID_PART 16'h0a5c
`define ID_MAKER 11'h155
`endif

/* File: scan_tap_properties.sv */
// Port checks for scan_tap.
// Bound into each scan_tap instance; sees its ports only.
`timescale 1ns/1ns
module tap_chk (
  input wire clk, // Clock
  input wire rstn, // Reset
  input wire tck, // Test clock
  input wire trst_n, // Test reset
  input wire tdo, // Data out
  input wire tdo_oe, // Enable
  input wire [7:0] core_out, // Core
  input wire [7:0] pin_in, // Pins
  input wire [7:0] pin_out, // Pins
  input wire [7:0] core_in, // Core
  input wire test_mode // Mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Test reset clears flops with no clock, so $past is kept clear of it
  wire live = rstn && trst_n;
  a_trst_clear: assert property (!trst_n |-> !test_mode && !tdo_oe) else $error("trst");
  a_core_pass: assert property ((live && !test_mode)[*2] |-> pin_out == $past(core_out)) else $error("pass");
  a_core_in: assert property (live[*2] |-> core_in == $past(pin_in)) else $error("core");
  a_tdo_fall: assert property (live[*2] ##0 $changed(tdo) |-> !$past(tck, 2)) else $error("tdo");
  a_oe_fall: assert property (live[*2] ##0 $changed(tdo_oe) |-> !$past(tck, 2)) else $error("oe");
  a_tdo_hold: assert property ((live && tck)[*8] |-> $stable(tdo) && $stable(tdo_oe)) else $error("hold");
  a_mode_edge: assert property (live[*2] ##0 $changed(test_mode) |-> $past(tck, 2)) else $error("mode");
  a_pin_hold: assert property ((live && test_mode)[*2] ##0 $changed(pin_out) |-> $past(tck, 2)) else $error("pin");
  c_mode: cover property (test_mode);
  c_oe: cover property (tdo_oe);
  c_trst: cover property (!trst_n);
endmodule
bind scan_tap tap_chk chk (.clk, .rstn, .tck, .trst_n, .tdo, .tdo_oe, .core_out, .pin_in, .pin_out, .core_in, .test_mode);

/* File: tester.sv */
// Board tester model driving the test pins.
// Caller starts each frame on a falling system clock edge.
`timescale 1ns/1ns
module tester (
  output logic tck, // Test clock
  output logic tms, // Mode select
  output logic tdi, // Data to device
  output logic trst_n, // Test reset
  input wire tdo // Data from device
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    #98 trst_n = 1'b1;
  end
  // Lsb first; tck stands still after the frame and tdi is spoiled
  task go(input logic [63:0] m, input logic [63:0] d, input int n, output logic [63:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      tms = m[i];
      tdi = d[i];
      #80 tck = 1'b1;
      q[i] = tdo;
      #80 tck = 1'b0;
    end
    tdi = ~tdi;
  endtask
  task pulse;
    trst_n = 1'b0;
    #160 trst_n = 1'b1;
  endtask
endmodule

/* File: testbench.sv */
// Bench for scan_tap driven by the tester model.
// Assumes the checker is bound in and every frame starts on a falling clk edge.
`timescale 1ns/1ns
`include "tap_defs.vh"
module testbench;
  logic clk, rstn, tck, tms, tdi, trst_n, tdo, tdo_oe, test_mode;
  logic [7:0] core_out, pin_in, pin_out, core_in;
  logic [63:0] q;
  int n_fail, check_count;
  localparam logic [31:0] ID = {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1};
  scan_tap dut (.clk, .rstn, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe, .core_out, .pin_in, .pin_out, .core_in, .test_mode);
  // A released tdo line reads inverted, so a missing tdo_oe spoils the shifted data
  tester h (.tck, .tms, .tdi, .trst_n, .tdo(tdo_oe ? tdo : ~tdo));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string s, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task ir(input logic [2:0] op);
    h.go(64'hc3, {57'h0, op, 4'h0}, 9, q);
    chk("ir", 64'h1, q[6:4]);
  endtask
  task dr(input int n, input logic [63:0] d);
    h.go(64'h1 | (64'h3 << (n + 2)), d << 3, n + 5, q);
    q = q >> 3;
  endtask
  task t_id;
    h.go(64'h0, 64'h0, 1, q);
    dr(32, 64'h0);
    chk("id", ID, q[31:0]);
  endtask
  task t_bypass;
    ir(`IR_BYPASS);
    dr(8, 64'hb5);
    chk("bypass", 64'h6a, q[7:0]);
  endtask
  task t_idcode;
    ir(`IR_IDCODE);
    dr(32, 64'h0);
    chk("idcode", ID, q[31:0]);
  endtask
  task t_extest;
    pin_in = 8'h3c;
    ir(`IR_EXTEST);
    dr(8, 64'ha6);
    chk("capture", 64'h3c, q[7:0]);
    chk("drive", 64'ha6, pin_out);
    chk("mode", 64'h1, test_mode);
  endtask
  task t_clamp;
    ir(`IR_CLAMP);
    dr(8, 64'h81);
    chk("clamp path", 64'h2, q[7:0]);
    chk("clamp pins", 64'ha6, pin_out);
  endtask
  task t_sample;
    core_out = 8'h5e;
    pin_in = 8'hc3;
    ir(`IR_SAMPLE);
    chk("through", 64'h5e, pin_out);
    dr(8, 64'h0f);
    chk("sample", 64'hc3, q[7:0]);
    chk("core", 64'hc3, core_in);
    ir(`IR_EXTEST);
    chk("preload", 64'h0f, pin_out);
  endtask
  task t_trst;
    h.pulse;
    chk("trst", 64'h0, test_mode);
    t_id;
    chk("idle", 64'h5e, pin_out);
  endtask
  task t_tlr;
    ir(`IR_EXTEST);
    chk("owned", 64'h1, test_mode);
    h.go(64'h7, 64'h0, 3, q);
    chk("tlr mode", 64'h0, test_mode);
    chk("tlr pins", 64'h5e, pin_out);
  endtask
  initial begin
    rstn = 1'b0;
    core_out = 8'h0;
    pin_in = 8'h0;
    repeat (16) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_id;
    t_bypass;
    t_idcode;
    t_extest;
    t_clamp;
    t_sample;
    t_trst;
    t_tlr;
    stop_test;
  end
  initial begin
    #100000 n_fail++;
    stop_test;
  end
endmodule
